// *** design/ftsr_port.sv ***
// Flow-through late-write burst memory: command decode, burst counter, array, data pins
// Notes on behaviour
// - Array holds 1,048,576 words of 18 bits
// - Synchronous inputs sampled on rising clock edge
// - Clock gate high freezes every operation
// - Chip selects sampled only when loading
// - Address captured only when selected and loading
// - Load low loads address, high advances burst
// - Advance ignores address, selects, read/write select
// - Read/write select picks type on load
// - Write command, enables, address registered together
// - Write data captured one clock after command
// - Read data flows out the next cycle
// - Reads and writes mix back to back
// - Each byte enable gates its own byte
// - Byte enables sampled on burst writes too
// - Data driven only when selected and enabled
// - Output enable acts without the clock
// - Writes need no output enable toggling
// - Deselect on a load cycle floats the data outputs
// - Order select low linear, high interleaved
// - Sleep request lowers power, keeps data
// - Two-bit burst counter wraps every four
// - Burst keeps type chosen at load
// - Drivers off during write cycles
// - Held cycle writes nothing, holds bus state
module ftsr_port
  import ftsr_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_gate_n,
  input  wire logic                    chip_sel_0_n,
  input  wire logic                    chip_sel_1,
  input  wire logic                    chip_sel_2_n,
  input  wire logic                    advance_or_load,
  input  wire logic                    read_write,
  input  wire logic [1:0]              byte_write_n,
  input  wire logic [ftsr_pkg::ADDR_W-1:0] addr,
  input  wire logic                    out_enable_n,
  input  wire logic                    linear_order_sel_n,
  input  wire logic                    sleep_request,
  input  wire logic [ftsr_pkg::DATA_W-1:0] dq_in,
  output logic [ftsr_pkg::DATA_W-1:0]  dq_out,
  output logic                         dq_oe,
  output logic                         write_busy,
  output logic                         sleeping
);
  import ftsr_pkg::*;

  ftsr_op_t           op_reg;
  ftsr_op_t           op_next;
  logic [ADDR_W-1:0]  base_reg;
  logic [BURST_W-1:0] count_reg;
  logic [ADDR_W-1:0]  step_addr;
  logic [ADDR_W-1:0]  rd_addr;
  logic [DATA_W-1:0]  rd_word;
  logic               rd_pend_reg;
  logic [DATA_W-1:0]  rd_data_reg;
  logic               selected;
  logic               load_cyc;
  logic               step_cyc;
  logic               wcmd_valid;
  ftsr_wcmd_t         wcmd;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  ftsr_wcmd_t         fifo_out;
  logic               wr_pend_reg;
  logic               fire;
  logic               land_cyc;
  logic               fwd_hit;

  // Burst address generation; one function serves the read path and the write commands
  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic               lin_n);
    if (lin_n) begin
      burst_low = start ^ cnt;
    end else begin
      burst_low = start + cnt;
    end
  endfunction

  // Sleep stops the port from accepting work; the array is untouched
  assign fire       = !clk_gate_n && !sleep_request;
  assign selected   = !chip_sel_0_n && chip_sel_1 && !chip_sel_2_n;
  assign load_cyc   = fire && !advance_or_load;
  assign step_cyc   = fire && advance_or_load && (op_reg != FTSR_IDLE);
  // Address of the next burst beat, shared by write commands and reads
  assign step_addr  = {base_reg[ADDR_W-1:BURST_W],
                       burst_low(base_reg[BURST_W-1:0], count_reg + BURST_ONE,
                                 linear_order_sel_n)};
  assign rd_addr    = load_cyc ? addr : step_addr;
  assign sleeping   = sleep_request;

  always_comb begin
    op_next = op_reg;
    if (load_cyc) begin
      if (!selected) begin
        op_next = FTSR_IDLE;
      end else if (read_write) begin
        op_next = FTSR_READ;
      end else begin
        op_next = FTSR_WRITE;
      end
    end
  end

  // Address and type capture on load; advance only steps the count
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg    <= FTSR_IDLE;
      base_reg  <= '0;
      count_reg <= '0;
    end else begin
      op_reg <= op_next;
      if (load_cyc && selected) begin
        base_reg  <= addr;
        count_reg <= BURST_ZERO;
      end else if (step_cyc) begin
        count_reg <= count_reg + BURST_ONE;
      end
    end
  end

  // Write commands wait in the FIFO for their data on the next edge
  always_comb begin
    wcmd_valid        = 1'b0;
    wcmd.addr         = addr;
    wcmd.byte_write_n = byte_write_n;
    if (load_cyc && selected && !read_write) begin
      wcmd_valid = 1'b1;
    end else if (step_cyc && op_reg == FTSR_WRITE) begin
      wcmd_valid = 1'b1;
      wcmd.addr  = step_addr;
    end
  end

  ftsr_fifo #(
    .WIDTH ($bits(ftsr_wcmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wcmd_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (wcmd_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (wcmd),
    .out_valid (fifo_out_valid),
    .out_ready (fire && wr_pend_reg),
    .out_data  (fifo_out)
  );

  // Data is due one enabled edge after its command; a held edge delays it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
    end else if (fire) begin
      wr_pend_reg <= wcmd_valid && fifo_in_ready;
    end
  end

  assign write_busy = fifo_out_valid;

  // Write data lands on the first enabled edge after its command
  assign land_cyc = fire && wr_pend_reg && fifo_out_valid;
  // A read of the word landing this edge sees the new bytes, so no dead cycle is needed
  assign fwd_hit  = land_cyc && (fifo_out.addr == rd_addr);

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W / BYTE_W; gi++) begin : g_lane
      // Each lane owns its storage so the lane write processes never share a variable
      logic [BYTE_W-1:0] lane_mem [DEPTH];
      always_ff @(posedge clk_sys) begin
        if (land_cyc && !fifo_out.byte_write_n[gi]) begin
          lane_mem[fifo_out.addr] <= dq_in[gi*BYTE_W +: BYTE_W];
        end
      end
      assign rd_word[gi*BYTE_W +: BYTE_W] =
        (fwd_hit && !fifo_out.byte_write_n[gi]) ? dq_in[gi*BYTE_W +: BYTE_W]
                                                : lane_mem[rd_addr];
    end
  endgenerate

  // Read flag and data registered so the pins follow in the next cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_reg <= 1'b0;
    end else if (fire) begin
      rd_pend_reg <= (op_next == FTSR_READ);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (fire) begin
      rd_data_reg <= rd_word;
    end
  end

  assign dq_out = rd_data_reg;
  // Enable is combinational in output enable so it acts without the clock
  assign dq_oe  = rd_pend_reg && !out_enable_n && !sleep_request;
endmodule

// *** design/ftsr_pkg.sv ***
// Shared constants and carrier types for the flow-through burst memory port
package ftsr_pkg;
  localparam int unsigned DATA_W      = 18;
  localparam int unsigned BYTE_W      = 9;
  localparam int unsigned ADDR_W      = 20;
  localparam int unsigned DEPTH       = 1048576;
  localparam int unsigned BURST_W     = 2;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam logic [1:0]  BW_NONE     = 2'h3;
  localparam logic [1:0]  BURST_ONE   = 2'h1;
  localparam logic [1:0]  BURST_ZERO  = 2'h0;

  // Access type carried from a load cycle into its burst
  typedef enum logic [1:0] {
    FTSR_IDLE  = 2'b00,
    FTSR_READ  = 2'b01,
    FTSR_WRITE = 2'b10
  } ftsr_op_t;

  // Write command held until its data arrives one clock later
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0]        byte_write_n;
  } ftsr_wcmd_t;
endpackage

// *** design/ftsr_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
module ftsr_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (PW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (PW+1)'(1);
      end
    end
  end
endmodule

// *** verification/ftsr_port_asserts.sv ***
// Concurrent checks on the burst memory port pins
module ftsr_chk
  import ftsr_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              clk_gate_n,
  input wire logic              chip_sel_0_n,
  input wire logic              chip_sel_1,
  input wire logic              chip_sel_2_n,
  input wire logic              advance_or_load,
  input wire logic              read_write,
  input wire logic              out_enable_n,
  input wire logic              sleep_request,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe,
  input wire logic              write_busy,
  input wire logic              sleeping
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic go;
  logic sel;
  logic ld;
  assign go = !clk_gate_n && !sleep_request;
  assign sel = !chip_sel_0_n && chip_sel_1 && !chip_sel_2_n;
  assign ld = go && !advance_or_load;
  sequence s_rd;
    ld && sel && read_write ##1 !out_enable_n && !sleep_request;
  endsequence
  sequence s_wr;
    ld && sel && !read_write;
  endsequence
  chk_oe_async: assert property (out_enable_n |-> !dq_oe)
    else $error("dq driven with output enable off");
  chk_sleep_float: assert property (sleep_request |-> !dq_oe && sleeping)
    else $error("dq driven or no sleep flag while asleep");
  chk_desel_float: assert property (ld && !sel |=> !dq_oe)
    else $error("dq driven after deselect");
  chk_read_drive: assert property (s_rd |-> dq_oe)
    else $error("read data not driven next cycle");
  chk_write_quiet: assert property (s_wr |=> !dq_oe)
    else $error("dq driven in write data cycle");
  chk_write_pend: assert property (s_wr |=> write_busy)
    else $error("write command not held");
  chk_write_drain: assert property (write_busy && ld && read_write |=> !write_busy)
    else $error("write data not taken one clock later");
  chk_hold_still: assert property (clk_gate_n && !sleep_request ##1
    !sleep_request && $stable(out_enable_n)
    |-> $stable(dq_out) && $stable(dq_oe) && $stable(write_busy))
    else $error("held edge changed the outputs");
endmodule

bind ftsr_port ftsr_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_gate_n(clk_gate_n),
  .chip_sel_0_n(chip_sel_0_n), .chip_sel_1(chip_sel_1), .chip_sel_2_n(chip_sel_2_n),
  .advance_or_load(advance_or_load), .read_write(read_write), .out_enable_n(out_enable_n),
  .sleep_request(sleep_request), .dq_out(dq_out), .dq_oe(dq_oe), .write_busy(write_busy),
  .sleeping(sleeping));

// *** verification/ftsr_host_model.sv ***
// Host data-phase model: puts write data on the bus one clock after its command
module ftsr_host
  import ftsr_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              drive,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] last_reg;
  // Idle bus shows the inverse of the last word, so a stale capture cannot pass
  assign dq_in = drive ? wdata : ~last_reg;
  always_ff @(posedge clk_sys) if (drive) last_reg <= wdata;
endmodule

// *** verification/tb.sv ***
// Bench for the burst memory port: host stimulus, expectation queue, read monitor
module tb;
  import ftsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, sys_rst = 1, clk_gate_n = 0, chip_sel_0_n = 1, chip_sel_1 = 1;
  logic chip_sel_2_n = 0, advance_or_load = 0, read_write = 1, out_enable_n = 0;
  logic linear_order_sel_n = 1, sleep_request = 0, drive = 0, wr_p = 0, dq_oe, write_busy, sleeping;
  logic [1:0] byte_write_n = 2'h3, wb, bk, bt = 2'h0;
  logic [ADDR_W-1:0] addr = '0, ba, wa, ca;
  logic [DATA_W-1:0] dq_in, dq_out, e, wdata = '0, mem_m [int], exp_q [$];
  int mismatches = 0, n_checks = 0;
  logic [31:0] lf = 32'h946a;
  ftsr_port DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_gate_n(clk_gate_n),
    .chip_sel_0_n(chip_sel_0_n), .chip_sel_1(chip_sel_1), .chip_sel_2_n(chip_sel_2_n),
    .advance_or_load(advance_or_load), .read_write(read_write), .byte_write_n(byte_write_n),
    .addr(addr), .out_enable_n(out_enable_n), .linear_order_sel_n(linear_order_sel_n),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .write_busy(write_busy), .sleeping(sleeping));
  ftsr_host u_host (.clk_sys(clk_sys), .drive(drive), .wdata(wdata), .dq_in(dq_in));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One command cycle; also lands the data owed to the previous write command
  task automatic step(input logic adv, rw, input logic [1:0] bw, cs, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    @(posedge clk_sys);
    d = lf[DATA_W-1:0];
    lf = nxt(lf);
    for (int b = 0; b < 2; b++)
      if (wr_p && !wb[b]) mem_m[wa][b*BYTE_W +: BYTE_W] = d[b*BYTE_W +: BYTE_W];
    drive <= wr_p;
    wdata <= d;
    clk_gate_n <= 0;
    advance_or_load <= adv;
    read_write <= rw;
    byte_write_n <= bw;
    addr <= a;
    chip_sel_0_n <= cs == 1;
    chip_sel_1 <= cs != 2;
    chip_sel_2_n <= cs == 3;
    if (sleep_request) bt = 2'h0;
    else if (!adv) begin
      bt = cs != 2'h0 ? 2'h0 : rw ? 2'h1 : 2'h2;
      ba = a;
      bk = 2'h0;
    end else bk++;
    ca = {ba[ADDR_W-1:2], linear_order_sel_n ? ba[1:0] ^ bk : ba[1:0] + bk};
    wr_p = bt == 2;
    wa = ca;
    wb = bw;
    if (bt == 1 && !out_enable_n) exp_q.push_back(mem_m[ca]);
  endtask
  always @(posedge clk_sys)
    if (!sys_rst && clk_gate_n === 1'b0 && sleep_request === 1'b0 && dq_oe === 1'b1) begin
      n_checks++;
      e = exp_q.size() ? exp_q.pop_front() : 'x;
      if (e !== dq_out) begin
        mismatches++;
        $display("BAD dq_out expected %h seen %h", e, dq_out);
      end
    end
  initial begin
    logic [ADDR_W-1:0] a;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 0;
    step(0, 1, 2'h3, 2'h1, '0);
    for (int m = 0; m < 2; m++) begin
      a = lf[ADDR_W-1:0];
      @(posedge clk_sys) linear_order_sel_n <= m[0];
      for (int k = 0; k < 4; k++) begin
        step(k != 0, 0, 2'h0, 0, a);
        if (k == 1) @(posedge clk_sys) clk_gate_n <= 1;
      end
      for (int k = 0; k < 4; k++) step(k != 0, 0, 2'(k), 0, a);
      // Advances carry junk on rw, selects and address: all must be ignored
      for (int k = 0; k < 6; k++) begin
        step(k != 0, k != 2, 2'h3, k == 3 ? 2'h1 : 2'h0, a ^ ADDR_W'(k));
        if (k == 1) @(posedge clk_sys) clk_gate_n <= 1;
      end
      // Upper byte written, then read back at once from the same word
      step(0, 0, 2'h1, 0, a);
      step(0, 1, 2'h3, 0, a);
      for (int c = 1; c < 4; c++) begin
        step(0, 1, 2'h3, 2'(c), a);
        step(1, 1, 2'h3, 0, a);
      end
      $display("test order %0d done", m);
    end
    @(posedge clk_sys) out_enable_n <= 1;
    step(0, 1, 2'h3, 0, a);
    step(0, 1, 2'h3, 2'h1, a);
    @(posedge clk_sys) out_enable_n <= 0;
    sleep_request <= 1;
    step(0, 1, 2'h3, 0, a);
    step(0, 1, 2'h3, 2'h1, a);
    @(posedge clk_sys) sleep_request <= 0;
    for (int k = 0; k < 4; k++) step(k != 0, 1, 2'h3, 0, a);
    repeat (3) step(0, 1, 2'h3, 2'h1, a);
    $display("test sleep done");
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("BAD reads expected 0 left seen %0d", exp_q.size());
    end
    tally_and_finish();
  end
  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
endmodule
